// File: pcrs_pkg.sv
// Shared constants and types for the PLL rate-select and output divider block.
// Assumes a single oscillator clock drives all logic and that no other block owns these names.
package pcrs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int PCRS_CLK_MHZ = 250;
    localparam int PCRS_STAB_TIME_US = 50;
    // Longest settle time rounds down to whole oscillator cycles
    localparam int PCRS_STAB_CYCLES = PCRS_STAB_TIME_US * PCRS_CLK_MHZ;
    localparam int PCRS_STAB_W = 14;

    // ------------------------------------------------------------
    // Divider and banks
    // ------------------------------------------------------------
    localparam int PCRS_DIV_W = 2;
    localparam int PCRS_DIV2_BIT = 0;
    localparam int PCRS_DIV4_BIT = 1;
    localparam int PCRS_BANK_W = 3;
    localparam int PCRS_SYNC_W = 6;
    localparam logic [PCRS_DIV_W-1:0] PCRS_DIV_RST = 2'h0;

    // ------------------------------------------------------------
    // Register map, byte addresses on a 32-bit Avalon-MM slave
    // ------------------------------------------------------------
    localparam int PCRS_ADDR_W = 4;
    localparam logic [PCRS_ADDR_W-1:0] PCRS_REG_STATUS = 4'h0;
    localparam logic [PCRS_ADDR_W-1:0] PCRS_REG_CONTROL = 4'h4;
    localparam logic [PCRS_ADDR_W-1:0] PCRS_REG_SETTLE = 4'h8;

    localparam int PCRS_ST_LOCKED = 0;
    localparam int PCRS_ST_B1_QUARTER = 1;
    localparam int PCRS_ST_TEST = 2;
    localparam int PCRS_ST_DRIVING = 3;
    localparam int PCRS_ST_DIV_LSB = 4;
    localparam int PCRS_ST_FEEDBACK = 6;
    localparam int PCRS_ST_REFERENCE = 7;

    localparam int PCRS_CTL_RESTART = 0;
    localparam int PCRS_CTL_HOLD = 1;
    localparam logic [1:0] PCRS_CTL_RST = 2'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic reference;
        logic feedback;
        logic clear_n;
        logic rate_select;
        logic enable_n;
        logic test;
    } pcrs_pins_s;

    typedef enum logic [2:0] {
        PCRS_LK_IDLE = 3'b001,
        PCRS_LK_ACQUIRE = 3'b010,
        PCRS_LK_LOCKED = 3'b100
    } pcrs_lock_e;

    typedef struct packed {
        logic [PCRS_BANK_W-1:0] bank_one;
        logic [PCRS_BANK_W-1:0] bank_two;
        logic enable_n;
    } pcrs_drive_s;

endpackage : pcrs_pkg

// File: pcrs_divider.sv
// Two-bit oscillator divider giving half and quarter rate phases.
// Assumes clear_in is a one-cycle pulse already on the oscillator clock.
`timescale 1ns/1ps

module pcrs_divider
    import pcrs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clear_in,
    output logic half_out,
    output logic quarter_out
);

    logic [PCRS_DIV_W-1:0] count_r;
    logic [PCRS_DIV_W-1:0] count_nxt;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_comb
    begin
        if (clear_in)
        begin
            count_nxt = PCRS_DIV_RST; // [R13] [R14]
        end
        else
        begin
            count_nxt = count_r + 2'h1; // [R01]
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            count_r <= PCRS_DIV_RST;
        end
        else
        begin
            count_r <= count_nxt;
        end
    end

    // Counter bits toggle evenly, so both phases have equal high and low time
    assign half_out = count_r[PCRS_DIV2_BIT]; // [R01] [R05]
    assign quarter_out = count_r[PCRS_DIV4_BIT]; // [R01] [R05]

endmodule : pcrs_divider

// File: pcrs_clock_core.sv
// Digital core of a six-output PLL clock driver: divider, bank select, enable and lock timer.
// Assumes core_clk_in is the controlled oscillator; reset and the Avalon-MM port are on it, all other pins asynchronous.
//
// Summary of operation
// (R01) Two-bit counter divides the oscillator into half and quarter rate, even duty.
// (R02) Rate select high: same phase on both banks; low: banks at different rates.
// (R03) Bank one carries half or quarter oscillator rate, chosen by rate select.
// (R04) Bank two always carries half the oscillator rate.
// (R05) Every output has even duty regardless of reference duty.
// (R06) Board wires exactly one output back to the feedback input.
// (R07) Unity output fed back: other bank doubled, or all at reference rate.
// (R08) Doubled arrangement: 2x outputs run at twice, 1x at reference rate.
// (R09) Doubled arrangement needs a reference between 25 and 50 MHz.
// (R10) Half-rate arrangement needs a reference between 50 and 100 MHz.
// (R11) Reference must hold fixed frequency and phase for lock.
// (R12) Reference duty must stay between 40 and 60 percent.
// (R13) Falling edge of the clear input forces the divider low.
// (R14) Half-rate phase is unknown at power-up; clear sets a known phase.
// (R15) Devices sharing reference and clear show equal half-rate phase after settling.
// (R16) Enable low drives all outputs; enable high releases them all.
// (R17) Enabling outputs restarts the settle interval.
// (R18) Outputs are not trusted until 50 us after select, clear, enable or power-up.
// (R19) Test high bypasses the loop; test low runs outputs from the loop.
// (R20) Test input is tied low in normal use.
// (R21) Divider and selection run on the oscillator; the loop is an ideal source.
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module pcrs_clock_core
    import pcrs_pkg::*;
#(
    parameter int STAB_CYCLES = PCRS_STAB_CYCLES
)
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic reference_clock_in,
    input wire logic loop_feedback_in,
    input wire logic half_rate_clear_n_in,
    input wire logic rate_select_in,
    input wire logic output_enable_n_in,
    input wire logic test_mode_in,
    output logic [PCRS_BANK_W-1:0] bank_one_out,
    output logic [PCRS_BANK_W-1:0] bank_two_out,
    output logic bank_oe_n_out,
    output logic locked_out,
    input wire logic [PCRS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);

    localparam logic [PCRS_STAB_W-1:0] SETTLE_LOAD = PCRS_STAB_W'(STAB_CYCLES);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PCRS_SYNC_W-1:0] raw_pins;
    logic [PCRS_SYNC_W-1:0] meta_r;
    logic [PCRS_SYNC_W-1:0] meta_nxt;
    logic [PCRS_SYNC_W-1:0] sync_r;
    logic [PCRS_SYNC_W-1:0] sync_nxt;
    pcrs_pins_s pins;

    assign raw_pins = {reference_clock_in, loop_feedback_in, half_rate_clear_n_in,
                       rate_select_in, output_enable_n_in, test_mode_in};

    genvar gi;
    generate
        for (gi = 0; gi < PCRS_SYNC_W; gi++)
        begin : g_sync
            always_comb
            begin
                meta_nxt[gi] = raw_pins[gi];
                sync_nxt[gi] = meta_r[gi];
            end

            always_ff @(posedge core_clk_in)
            begin
                meta_r[gi] <= meta_nxt[gi];
                sync_r[gi] <= sync_nxt[gi];
            end
        end
    endgenerate

    assign pins = pcrs_pins_s'(sync_r);

    // ------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------
    // Previous levels of clear, enable and select, in that order
    logic [2:0] prev_r;
    logic [2:0] prev_nxt;
    logic clear_fall;
    logic enable_fall;
    logic select_change;

    always_comb
    begin
        prev_nxt = {pins.clear_n, pins.enable_n, pins.rate_select};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            // Clear and enable idle high so reset release raises no falling edge; select loads low
            prev_r <= 3'h6;
        end
        else
        begin
            prev_r <= prev_nxt;
        end
    end

    // Only the high-to-low transition counts; a held low clear does nothing more
    assign clear_fall = prev_r[2] & ~pins.clear_n; // [R13]
    assign enable_fall = prev_r[1] & ~pins.enable_n; // [R17]
    assign select_change = prev_r[0] ^ pins.rate_select;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    logic half_phase;
    logic quarter_phase;

    // Clear is taken synchronously after the pin synchroniser; every device
    // sharing the clear and reference therefore lands on the same count
    pcrs_divider u_divider
    (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(clear_fall), // [R13] [R15] [R21]
        .half_out(half_phase),
        .quarter_out(quarter_phase)
    );

    // ------------------------------------------------------------
    // Bank selection and output drive
    // ------------------------------------------------------------
    pcrs_drive_s drive_r;
    pcrs_drive_s drive_nxt;
    logic one_phase;

    always_comb
    begin
        // High keeps both banks on the half phase; low moves bank one to quarter
        one_phase = pins.rate_select ? half_phase : quarter_phase; // [R02] [R03] [R07]
        drive_nxt.bank_one = {PCRS_BANK_W{one_phase}}; // [R03]
        drive_nxt.bank_two = {PCRS_BANK_W{half_phase}}; // [R04] [R08]
        if (pins.test)
        begin
            // Bypass the loop: every output follows the reference pin directly
            drive_nxt.bank_one = {PCRS_BANK_W{pins.reference}}; // [R19]
            drive_nxt.bank_two = {PCRS_BANK_W{pins.reference}}; // [R19]
        end
        drive_nxt.enable_n = pins.enable_n; // [R16]
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            drive_r <= '0;
            drive_r.enable_n <= 1'b1;
        end
        else
        begin
            drive_r <= drive_nxt;
        end
    end

    assign bank_one_out = drive_r.bank_one;
    assign bank_two_out = drive_r.bank_two;
    assign bank_oe_n_out = drive_r.enable_n; // [R16]

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [1:0] ctl_r;
    logic [1:0] ctl_nxt;
    logic sw_restart;
    logic wr_take;

    // A request is taken at the edge where waitrequest is seen low
    assign wr_take = avs_write_in & ~avs_waitrequest_out;

    always_comb
    begin
        ctl_nxt = ctl_r;
        ctl_nxt[PCRS_CTL_RESTART] = 1'b0;
        if (wr_take && avs_address_in == PCRS_REG_CONTROL && avs_byteenable_in[0])
        begin
            ctl_nxt = avs_writedata_in[1:0];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctl_r <= PCRS_CTL_RST;
        end
        else
        begin
            ctl_r <= ctl_nxt;
        end
    end

    assign sw_restart = ctl_r[PCRS_CTL_RESTART] | ctl_r[PCRS_CTL_HOLD];

    // ------------------------------------------------------------
    // Settle timer
    // ------------------------------------------------------------
    pcrs_lock_e lock_r;
    pcrs_lock_e lock_nxt;
    logic [PCRS_STAB_W-1:0] settle_r;
    logic [PCRS_STAB_W-1:0] settle_nxt;
    logic restart;

    // The loop sees a new reference or feedback path on clear, enable or select; sw_restart is a software request
    assign restart = clear_fall | enable_fall | select_change | sw_restart; // [R17] [R18]

    always_comb
    begin
        lock_nxt = lock_r;
        settle_nxt = settle_r;
        case (lock_r)
            PCRS_LK_IDLE:
            begin
                // Released outputs break the feedback path, so no lock is claimed
                if (!pins.enable_n && !pins.test && !sw_restart)
                begin
                    lock_nxt = PCRS_LK_ACQUIRE;
                    settle_nxt = SETTLE_LOAD; // [R17]
                end
            end
            PCRS_LK_ACQUIRE:
            begin
                if (restart)
                begin
                    settle_nxt = SETTLE_LOAD; // [R18]
                end
                else if (settle_r == '0)
                begin
                    lock_nxt = PCRS_LK_LOCKED;
                end
                else
                begin
                    settle_nxt = settle_r - 1'b1;
                end
            end
            PCRS_LK_LOCKED:
            begin
                if (restart)
                begin
                    lock_nxt = PCRS_LK_ACQUIRE;
                    settle_nxt = SETTLE_LOAD; // [R18]
                end
            end
            default: lock_nxt = PCRS_LK_IDLE;
        endcase
        if (pins.enable_n || pins.test)
        begin
            lock_nxt = PCRS_LK_IDLE; // [R19]
            settle_nxt = '0;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            lock_r <= PCRS_LK_IDLE;
            settle_r <= '0;
            locked_out <= 1'b0;
        end
        else
        begin
            lock_r <= lock_nxt;
            settle_r <= settle_nxt;
            locked_out <= (lock_nxt == PCRS_LK_LOCKED);
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait state on every access
    // ------------------------------------------------------------
    logic wait_nxt;
    logic [31:0] rdata_nxt;

    always_comb
    begin
        wait_nxt = 1'b1;
        rdata_nxt = avs_readdata_out; // Read data stand through the accepting edge
        if (avs_waitrequest_out && (avs_read_in || avs_write_in))
        begin
            wait_nxt = 1'b0;
            rdata_nxt = 32'h0;
            if (avs_address_in == PCRS_REG_STATUS)
            begin
                rdata_nxt[PCRS_ST_LOCKED] = (lock_r == PCRS_LK_LOCKED);
                rdata_nxt[PCRS_ST_B1_QUARTER] = ~pins.rate_select;
                rdata_nxt[PCRS_ST_TEST] = pins.test;
                rdata_nxt[PCRS_ST_DRIVING] = ~drive_r.enable_n;
                rdata_nxt[PCRS_ST_DIV_LSB +: PCRS_DIV_W] = {quarter_phase, half_phase};
                rdata_nxt[PCRS_ST_FEEDBACK] = pins.feedback;
                rdata_nxt[PCRS_ST_REFERENCE] = pins.reference;
            end
            else if (avs_address_in == PCRS_REG_CONTROL)
            begin
                rdata_nxt[1:0] = ctl_r;
            end
            else if (avs_address_in == PCRS_REG_SETTLE)
            begin
                rdata_nxt[PCRS_STAB_W-1:0] = settle_r;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h0;
        end
        else
        begin
            avs_waitrequest_out <= wait_nxt;
            avs_readdata_out <= rdata_nxt;
        end
    end

endmodule : pcrs_clock_core

// File: pcrs_clock_core_properties.sv
// Concurrent checks on the ports of the clock core.
// Assumes one oscillator clock and a synchronous active-high reset.
`timescale 1ns/1ps

module pcrs_clock_core_properties
    import pcrs_pkg::*;
#(
    parameter int STAB_CYCLES = PCRS_STAB_CYCLES
)
(
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic reference_clock_in,
    input wire logic half_rate_clear_n_in,
    input wire logic rate_select_in,
    input wire logic output_enable_n_in,
    input wire logic test_mode_in,
    input wire logic [PCRS_BANK_W-1:0] bank_one_out,
    input wire logic [PCRS_BANK_W-1:0] bank_two_out,
    input wire logic bank_oe_n_out,
    input wire logic locked_out,
    input wire logic [PCRS_ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out
);
    // ----
    // Helpers
    // ----
    logic quiet;
    logic [31:0] low_cnt_r;
    logic [31:0] low_cnt_nxt;
    // A clear edge may stall the divider, so toggle checks wait for a quiet window
    assign quiet = !sys_rst_in && !test_mode_in && half_rate_clear_n_in;
    always_comb low_cnt_nxt = locked_out ? 32'h0 : low_cnt_r + 32'h1;
    always_ff @(posedge core_clk_in) low_cnt_r <= sys_rst_in ? 32'h0 : low_cnt_nxt;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_half_toggle;
        quiet [*8] |-> bank_two_out != $past(bank_two_out);
    endproperty
    a_half_toggle: assert property (p_half_toggle)
        else $error("bank two missed a toggle");
    property p_same_phase;
        (quiet && rate_select_in) [*6] |-> bank_one_out == bank_two_out;
    endproperty
    a_same_phase: assert property (p_same_phase)
        else $error("banks differ with select high");
    property p_quarter;
        (quiet && !rate_select_in) [*8] |-> bank_one_out == ~$past(bank_one_out, 2);
    endproperty
    a_quarter: assert property (p_quarter)
        else $error("bank one not at quarter rate");
    property p_oe_off;
        output_enable_n_in [*6] |-> bank_oe_n_out && !locked_out;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("outputs not released");
    property p_oe_on;
        !output_enable_n_in [*6] |-> !bank_oe_n_out;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("outputs not driven");
    property p_sel_restart;
        $changed(rate_select_in) |-> ##[1:8] !locked_out;
    endproperty
    a_sel_restart: assert property (p_sel_restart)
        else $error("select change kept lock");
    property p_lock_time;
        $rose(locked_out) |-> low_cnt_r >= STAB_CYCLES;
    endproperty
    a_lock_time: assert property (p_lock_time)
        else $error("lock claimed too early");
    property p_bypass;
        test_mode_in [*6] |-> bank_one_out == {PCRS_BANK_W{$past(reference_clock_in, 3)}}
            && !locked_out;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("test mode not following reference");
    property p_wait_one;
        (avs_read_in || avs_write_in) && avs_waitrequest_out |=>
            !avs_waitrequest_out ##1 avs_waitrequest_out;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("bus answer not one cycle");
    property p_unmapped;
        avs_read_in && !avs_waitrequest_out && avs_address_in > 4'h8 |-> avs_readdata_out == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
endmodule : pcrs_clock_core_properties

bind pcrs_clock_core pcrs_clock_core_properties #(.STAB_CYCLES(STAB_CYCLES)) props_i (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .reference_clock_in(reference_clock_in), .half_rate_clear_n_in(half_rate_clear_n_in),
    .rate_select_in(rate_select_in), .output_enable_n_in(output_enable_n_in),
    .test_mode_in(test_mode_in), .bank_one_out(bank_one_out), .bank_two_out(bank_two_out),
    .bank_oe_n_out(bank_oe_n_out), .locked_out(locked_out), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out));

// File: pcrs_ref_model.sv
// Reference source and board wiring seen by the clock core.
// Assumes bank two bit 0 is the output wired back to the feedback pin.
`timescale 1ns/1ps

module pcrs_ref_model
    import pcrs_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic [PCRS_BANK_W-1:0] bank_two_in,
    input wire logic bank_oe_n_in,
    output logic reference_clock_out,
    output logic loop_feedback_out
);
    logic ref_r = 1'b0;
    logic float_r = 1'b0;
    // Fixed frequency and phase, even duty, half the oscillator rate
    always @(posedge core_clk_in) ref_r <= ~ref_r;
    // A released line has no pull, so it wanders rather than keep its level
    always @(posedge core_clk_in) float_r <= ~float_r;
    assign loop_feedback_out = bank_oe_n_in ? float_r : bank_two_in[0];
    assign reference_clock_out = ref_r;
endmodule : pcrs_ref_model

// File: pcrs_clock_core_tb.sv
// Self-checking bench for the clock core with an Avalon-MM master.
// Assumes the reference model drives the reference and feedback pins.
`timescale 1ns/1ps

module pcrs_clock_core_tb
    import pcrs_pkg::*;
;
    localparam int STAB = 20;
    logic clk = 1'b0, rst = 1'b1, ref_clk, fb, clr_n = 1'b1, sel = 1'b1, oe_n = 1'b1;
    logic tst = 1'b0;
    logic [2:0] b1, b2;
    logic boe_n, lck, rd = 1'b0, wr = 1'b0, wreq, v1, v2;
    logic [3:0] addr = 4'h0, be = 4'hF;
    logic [31:0] wdata = 32'h0, rdata, q;
    int miscompares = 0, n_compared = 0, cyc = 0, n1, n2;

    always #2 clk = ~clk;

    pcrs_clock_core #(.STAB_CYCLES(STAB)) pcrs_clock_core_i (.core_clk_in(clk),
        .sys_rst_in(rst), .reference_clock_in(ref_clk), .loop_feedback_in(fb),
        .half_rate_clear_n_in(clr_n), .rate_select_in(sel), .output_enable_n_in(oe_n),
        .test_mode_in(tst), .bank_one_out(b1), .bank_two_out(b2), .bank_oe_n_out(boe_n),
        .locked_out(lck), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq));
    pcrs_ref_model pcrs_ref_model_i (.core_clk_in(clk), .bank_two_in(b2),
        .bank_oe_n_in(boe_n), .reference_clock_out(ref_clk), .loop_feedback_out(fb));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] e);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        be <= e;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(q & m, exp);
    endtask : rdchk

    // Lock must be absent early, then appear between STAB and STAB + 16 cycles
    task relock;
        int n;
        n = 8;
        repeat (8) @(posedge clk);
        chk(lck, 1'b0);
        while (lck !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        chk(n >= STAB && n <= STAB + 16, 1'b1);
    endtask : relock

    task toggles;
        logic [2:0] p1, p2;
        p1 = b1;
        p2 = b2;
        n1 = 0;
        n2 = 0;
        repeat (16)
        begin
            @(posedge clk);
            n1 += int'(b1 !== p1);
            n2 += int'(b2 !== p2);
            p1 = b1;
            p2 = b2;
        end
    endtask : toggles

    // Clear held low well past its edge; the divider must keep running
    task clr_pulse(output logic v);
        @(posedge clk);
        clr_n <= 1'b0;
        repeat (12) @(posedge clk);
        v = b2[0];
        @(posedge clk);
        chk(b2[0], !v);
        chk(lck, 1'b0);
        repeat (7) @(posedge clk);
        clr_n <= 1'b1;
    endtask : clr_pulse

    task report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(boe_n, 1'b1);
        rdchk(PCRS_REG_CONTROL, 32'h0, 32'hFFFFFFFF);
        rdchk(4'hC, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, 4'hC, 32'hFFFFFFFF, 4'hF);
        rdchk(PCRS_REG_STATUS, 32'h0, 32'hF);
        $display("reset test done");
        oe_n <= 1'b0;
        relock();
        rdchk(PCRS_REG_STATUS, 32'h9, 32'hF);
        toggles();
        chk(n1, 16);
        chk(n2, 16);
        sel <= 1'b0;
        relock();
        toggles();
        chk(n1, 8);
        chk(n2, 16);
        rdchk(PCRS_REG_STATUS, 32'hB, 32'hF);
        sel <= 1'b1;
        relock();
        $display("select test done");
        clr_pulse(v1);
        clr_pulse(v2);
        chk(v2, v1);
        while (lck !== 1'b1) @(posedge clk);
        $display("clear test done");
        oe_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk(boe_n, 1'b1);
        rdchk(PCRS_REG_STATUS, 32'h0, 32'hF);
        oe_n <= 1'b0;
        relock();
        $display("enable test done");
        bus(1'b1, PCRS_REG_CONTROL, 32'h1, 4'hF);
        relock();
        bus(1'b1, PCRS_REG_CONTROL, 32'h2, 4'hF);
        repeat (40) @(posedge clk);
        chk(lck, 1'b0);
        rdchk(PCRS_REG_SETTLE, STAB, 32'hFFFF);
        rdchk(PCRS_REG_CONTROL, 32'h2, 32'h3);
        bus(1'b1, PCRS_REG_CONTROL, 32'h0, 4'h0);
        rdchk(PCRS_REG_CONTROL, 32'h2, 32'h3);
        bus(1'b1, PCRS_REG_CONTROL, 32'h0, 4'hF);
        relock();
        $display("control test done");
        tst <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(PCRS_REG_STATUS, 32'hC, 32'hF);
        tst <= 1'b0;
        relock();
        $display("test mode test done");
        report_and_stop();
    end
endmodule : pcrs_clock_core_tb
